// *** rtl/ssf_sequencer.sv ***
// What this block does
// RULE_01 - Six input voltage limits, L11 volts, compared
// RULE_02 - Four temperature limits, L11 Celsius, supervised
// RULE_03 - Turn-on wait before enable, shared ticks only
// RULE_04 - Mode 00: ramp time, then trim soft-connect
// RULE_05 - Reach undervoltage level in time, else timeout
// RULE_06 - Zero start timeout means no limit
// RULE_07 - Turn-off wait, shared clock else internal tick
// RULE_08 - Timers run on 10 us tick, share-synced
// RULE_09 - L11 ms rounded to 10 us, max 655 ms
// RULE_10 - Output faults set status bits, pull alert low
// RULE_11 - Current-sense odd channel ignores output faults
// RULE_12 - Action 00 keeps channel running
// RULE_13 - Action 01 waits delay samples, then shuts down
// RULE_14 - Action 1x shuts down, then follows retry
// RULE_15 - Retry 000 stays off until faults cleared
// RULE_16 - Retry nonzero restarts forever after retry wait
// RULE_17 - Retry setting taken at off-then-on
// RULE_18 - Delay 000 immediate, else n samples ignored
// RULE_19 - Without shared edges start timers hold
`default_nettype none
module ssf_sequencer
  import ssf_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int ALIVE_CYCLES = ALIVE_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire ssf_cmd_t cmd,
  output logic [15:0] cmd_rdata,
  input wire logic channel_on_pin,
  input wire logic operation_on,
  input wire logic share_clk,
  input wire logic [1:0] dac_mode,
  input wire logic current_sense_mode,
  input wire logic out_over_detect,
  input wire logic out_under_detect,
  input wire logic clear_faults,
  input wire logic [15:0] retry_wait_ticks,
  input wire logic [15:0] sensed_input_voltage,
  input wire logic [15:0] die_temperature,
  output logic supply_enable,
  output logic trim_connect,
  output logic [7:0] vout_status,
  output logic [7:0] summary_byte,
  output logic [15:0] summary_word,
  output ssf_limit_flags_t limit_flags,
  output logic alert_line_low_oe
);

  initial begin
    if (TICK_CYCLES < 2 || TICK_CYCLES > 256) begin
      $error("TICK_CYCLES out of range");
    end
    if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 256) begin
      $error("SAMPLE_CYCLES out of range");
    end
    // The alive window must outlast one tick or turn-off would stall
    if (ALIVE_CYCLES <= TICK_CYCLES || ALIVE_CYCLES > 1023) begin
      $error("ALIVE_CYCLES out of range");
    end
    if (TICK_MAX > 17'(655 * TICK_PER_MS)) begin
      $error("TICK_MAX beyond the timer range");
    end
  end

  // L11 value as signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] l11_fix(input logic [15:0] w);
    logic signed [47:0] m;
    logic [5:0] sh;
    m = 48'($signed(w[10:0]));
    sh = 6'($signed({w[15], w[15:11]}) + 6'sd16);
    return m <<< sh;
  endfunction

  // L11 milliseconds to 10 us ticks, rounded to nearest, saturated
  function automatic logic [16:0] l11_ticks(input logic [15:0] w);
    logic [47:0] p;
    logic [47:0] q;
    logic [4:0] ne;
    p = w[10] ? 48'h0000_0000_0000 : 48'(w[9:0]) * 48'(TICK_PER_MS);
    ne = 5'(-$signed(w[15:11]));
    if (!w[15]) begin
      q = p << w[15:11];
    end else begin
      q = (p + (48'h0000_0000_0001 << (ne - 5'h01))) >> ne;
    end
    return (q > 48'(TICK_MAX)) ? TICK_MAX : q[16:0];
  endfunction

  // Deglitch step: returns {shut, next count}
  function automatic logic [3:0] fault_step(input logic hit, input logic [7:0] act,
                                            input logic [2:0] deg, input logic samp);
    logic [3:0] r;
    r = 4'h0;
    if (hit && act[ACT_HI:ACT_LO] != ACT_IGNORE) begin // RULE_12
      if (deg == act[DELAY_HI:DELAY_LO]) begin // RULE_18
        r = {1'b1, deg}; // RULE_13 RULE_14
      end else begin
        r = {1'b0, samp ? 3'(deg + 3'h1) : deg}; // RULE_13
      end
    end
    return r;
  endfunction

  // Count-down step shared by every sequencing timer, stops at zero
  function automatic logic [16:0] dec17(input logic [16:0] v);
    return (v == 17'h0_0000) ? v : 17'(v - 17'h0_0001);
  endfunction

  ssf_state_reg_t s, n;
  logic share_edge;
  logic share_alive;
  logic int_tick;
  logic off_tick;
  logic samp_tick;
  logic on_req;
  logic ov_hit;
  logic uv_hit;
  logic [3:0] ov_res;
  logic [3:0] uv_res;
  logic ton_max_fault;
  logic [16:0] max_ticks;
  logic shut;
  logic signed [47:0] vin;
  logic signed [47:0] tmp;

  always_comb begin
    n = s;
    n.sync1 = {channel_on_pin, out_over_detect, out_under_detect};
    n.sync2 = s.sync1;
    n.share_s1 = share_clk;
    n.share_s2 = s.share_s1;
    n.share_prev = s.share_s2;

    // Time base
    share_edge = s.share_s2 && !s.share_prev;
    share_alive = s.alive_cnt != 10'h000;
    if (share_edge) begin
      n.alive_cnt = 10'(ALIVE_CYCLES);
    end else if (share_alive) begin
      n.alive_cnt = 10'(s.alive_cnt - 10'h001);
    end
    int_tick = s.tick_div == 8'(TICK_CYCLES - 1);
    if (share_edge || int_tick) begin
      n.tick_div = 8'h00; // RULE_08
    end else begin
      n.tick_div = 8'(s.tick_div + 8'h01);
    end
    // Turn-off falls back to the free tick when the shared clock stops
    off_tick = share_alive ? share_edge : int_tick; // RULE_07
    samp_tick = s.samp_div == 8'(SAMPLE_CYCLES - 1);
    if (samp_tick) begin
      n.samp_div = 8'h00;
    end else begin
      n.samp_div = 8'(s.samp_div + 8'h01);
    end

    // Register port
    if (cmd.valid && cmd.write) begin
      if (cmd.index >= IDX_OUT_OVER_ACTION) begin
        // Action words are one byte; the upper byte reads back as zero
        n.regs[cmd.index] = cmd.wdata & BYTE_MASK;
      end else begin
        n.regs[cmd.index] = cmd.wdata;
      end
    end
    if (cmd.valid && !cmd.write) begin
      n.rdata = s.regs[cmd.index];
    end

    // Limit supervision
    vin = l11_fix(sensed_input_voltage);
    tmp = l11_fix(die_temperature);
    n.flags.vin[0] = vin >= l11_fix(s.regs[IDX_VIN_ON]); // RULE_01
    n.flags.vin[1] = vin < l11_fix(s.regs[IDX_VIN_OFF]); // RULE_01
    n.flags.vin[2] = vin > l11_fix(s.regs[IDX_VIN_OV_FAULT]); // RULE_01
    n.flags.vin[3] = vin > l11_fix(s.regs[IDX_VIN_OV_WARN]); // RULE_01
    n.flags.vin[4] = vin < l11_fix(s.regs[IDX_VIN_UV_WARN]); // RULE_01
    n.flags.vin[5] = vin < l11_fix(s.regs[IDX_VIN_UV_FAULT]); // RULE_01
    n.flags.temp[0] = tmp > l11_fix(s.regs[IDX_HOT_FAULT]); // RULE_02
    n.flags.temp[1] = tmp > l11_fix(s.regs[IDX_HOT_WARN]); // RULE_02
    n.flags.temp[2] = tmp < l11_fix(s.regs[IDX_COLD_WARN]); // RULE_02
    n.flags.temp[3] = tmp < l11_fix(s.regs[IDX_COLD_FAULT]); // RULE_02

    // Output faults, only while the supply is driven
    on_req = s.sync2[2] || operation_on;
    ov_hit = s.sync2[1] && s.supply_en && !current_sense_mode; // RULE_11
    uv_hit = s.sync2[0] && s.supply_en && s.uv_unmask && !current_sense_mode; // RULE_11
    ov_res = fault_step(ov_hit, s.regs[IDX_OUT_OVER_ACTION][7:0], s.ov_deg, samp_tick);
    uv_res = fault_step(uv_hit, s.regs[IDX_OUT_UNDER_ACTION][7:0], s.uv_deg, samp_tick);
    n.ov_deg = ov_res[2:0];
    n.uv_deg = uv_res[2:0];
    max_ticks = l11_ticks(s.regs[IDX_START_TIMEOUT]);
    ton_max_fault = 1'b0;
    shut = ov_res[3] || uv_res[3];

    // Start timeout runs until the output clears its undervoltage level
    if ((s.state == SSF_RISE || s.state == SSF_RUN) && !s.uv_unmask) begin
      if (!s.sync2[0]) begin
        n.uv_unmask = 1'b1; // RULE_05
      end else if (max_ticks != 17'h0_0000) begin // RULE_06
        if (s.max_cnt == 17'h0_0000) begin
          ton_max_fault = 1'b1; // RULE_05
        end else if (share_edge) begin
          n.max_cnt = dec17(s.max_cnt); // RULE_05 RULE_19
        end
      end
    end

    // Status: a new event wins over a clear in the same cycle
    if (clear_faults) begin
      n.vout_status = 8'h00;
      n.sum_byte = 8'h00;
      n.sum_word = 16'h0000;
    end
    if (ov_hit) begin
      n.vout_status[VS_OV_FAULT] = 1'b1; // RULE_10
      n.sum_byte[SB_VOUT_OV] = 1'b1; // RULE_10
      n.sum_word[SB_VOUT_OV] = 1'b1; // RULE_10
      n.sum_word[SW_VOUT] = 1'b1; // RULE_10
    end
    if (uv_hit) begin
      n.vout_status[VS_UV_FAULT] = 1'b1; // RULE_10
    end
    if (ton_max_fault) begin
      n.vout_status[VS_TON_MAX] = 1'b1; // RULE_05
    end
    if (uv_hit || ton_max_fault) begin
      n.sum_byte[SB_OTHER] = 1'b1; // RULE_10
      n.sum_word[SB_OTHER] = 1'b1; // RULE_10
      n.sum_word[SW_VOUT] = 1'b1; // RULE_10
    end

    // Channel sequence
    case (s.state)
      SSF_OFF: begin
        n.supply_en = 1'b0;
        n.trim_connect = 1'b0;
        if (on_req) begin
          // Retry fields latched here, so a new write waits for the next cycle on
          n.ov_retry = s.regs[IDX_OUT_OVER_ACTION][RETRY_HI:RETRY_LO]; // RULE_17
          n.uv_retry = s.regs[IDX_OUT_UNDER_ACTION][RETRY_HI:RETRY_LO]; // RULE_17
          n.cnt = l11_ticks(s.regs[IDX_TURN_ON_WAIT]); // RULE_09
          n.state = SSF_ON_WAIT;
        end
      end
      SSF_ON_WAIT: begin
        if (!on_req) begin
          n.state = SSF_OFF;
        end else if (s.cnt == 17'h0_0000) begin
          n.supply_en = 1'b1; // RULE_03
          n.uv_unmask = 1'b0;
          n.cnt = l11_ticks(s.regs[IDX_RAMP_TIME]); // RULE_09
          n.max_cnt = max_ticks;
          n.state = SSF_RISE;
        end else if (share_edge) begin
          n.cnt = dec17(s.cnt); // RULE_03 RULE_19
        end
      end
      SSF_RISE, SSF_RUN: begin
        if (shut || ton_max_fault) begin
          n.supply_en = 1'b0; // RULE_13 RULE_14
          n.trim_connect = 1'b0;
          n.uv_unmask = 1'b0;
          if (ton_max_fault || (ov_res[3] ? s.ov_retry : s.uv_retry) == 3'h0) begin
            n.state = SSF_LATCHED; // RULE_15
          end else begin
            n.cnt = {1'b0, retry_wait_ticks}; // RULE_16
            n.state = SSF_RETRY_WAIT;
          end
        end else if (!on_req) begin
          n.cnt = l11_ticks(s.regs[IDX_TURN_OFF_WAIT]); // RULE_09
          n.state = SSF_OFF_WAIT;
        end else if (s.state == SSF_RISE) begin
          if (s.cnt == 17'h0_0000) begin
            n.trim_connect = dac_mode == DAC_MODE_SOFT; // RULE_04
            n.state = SSF_RUN;
          end else if (share_edge) begin
            n.cnt = dec17(s.cnt); // RULE_04 RULE_19
          end
        end
      end
      SSF_OFF_WAIT: begin
        if (shut) begin
          n.supply_en = 1'b0;
          n.trim_connect = 1'b0;
          n.state = SSF_OFF;
        end else if (on_req) begin
          n.state = s.trim_connect ? SSF_RUN : SSF_RISE;
        end else if (s.cnt == 17'h0_0000) begin
          n.supply_en = 1'b0; // RULE_07
          n.trim_connect = 1'b0;
          n.uv_unmask = 1'b0;
          n.state = SSF_OFF;
        end else if (off_tick) begin
          n.cnt = dec17(s.cnt); // RULE_07
        end
      end
      SSF_RETRY_WAIT: begin
        if (!on_req) begin
          n.state = SSF_OFF; // RULE_16
        end else if (s.cnt == 17'h0_0000) begin
          n.cnt = l11_ticks(s.regs[IDX_TURN_ON_WAIT]);
          n.state = SSF_ON_WAIT; // RULE_16
        end else if (off_tick) begin
          n.cnt = dec17(s.cnt);
        end
      end
      SSF_LATCHED: begin
        if (clear_faults) begin
          n.state = SSF_OFF; // RULE_15
        end
      end
      default: begin
        n.state = SSF_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
      s.regs <= {16{REG_RST}};
      s.state <= SSF_OFF;
    end else begin
      s <= n;
    end
  end

  assign cmd_rdata = s.rdata;
  assign supply_enable = s.supply_en;
  assign trim_connect = s.trim_connect;
  assign vout_status = s.vout_status;
  assign summary_byte = s.sum_byte;
  assign summary_word = s.sum_word;
  assign limit_flags = s.flags;
  // Held low while any output fault bit stands
  assign alert_line_low_oe = s.vout_status != 8'h00; // RULE_10

endmodule // ssf_sequencer
`default_nettype wire

// *** rtl/ssf_pkg.sv ***
`default_nettype none
package ssf_pkg;
  // Clock and time base
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_NS = 10_000;
  localparam int TICK_CYC = TICK_NS / (1_000_000_000 / CLK_HZ);
  localparam int SAMPLE_NS = 12_200;
  localparam int SAMPLE_CYC = SAMPLE_NS / (1_000_000_000 / CLK_HZ);
  localparam int SHARE_LOSS_TICKS = 2;
  localparam int ALIVE_CYC = SHARE_LOSS_TICKS * TICK_CYC;
  localparam int TICK_PER_MS = 100;
  localparam logic [16:0] TICK_MAX = 17'h0_FFDC;

  // Command indices of the limit, timer and fault action words
  localparam logic [3:0] IDX_VIN_ON = 4'h0;
  localparam logic [3:0] IDX_VIN_OFF = 4'h1;
  localparam logic [3:0] IDX_VIN_OV_FAULT = 4'h2;
  localparam logic [3:0] IDX_VIN_OV_WARN = 4'h3;
  localparam logic [3:0] IDX_VIN_UV_WARN = 4'h4;
  localparam logic [3:0] IDX_VIN_UV_FAULT = 4'h5;
  localparam logic [3:0] IDX_HOT_FAULT = 4'h6;
  localparam logic [3:0] IDX_HOT_WARN = 4'h7;
  localparam logic [3:0] IDX_COLD_WARN = 4'h8;
  localparam logic [3:0] IDX_COLD_FAULT = 4'h9;
  localparam logic [3:0] IDX_TURN_ON_WAIT = 4'hA;
  localparam logic [3:0] IDX_RAMP_TIME = 4'hB;
  localparam logic [3:0] IDX_START_TIMEOUT = 4'hC;
  localparam logic [3:0] IDX_TURN_OFF_WAIT = 4'hD;
  localparam logic [3:0] IDX_OUT_OVER_ACTION = 4'hE;
  localparam logic [3:0] IDX_OUT_UNDER_ACTION = 4'hF;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] BYTE_MASK = 16'h00FF;

  // Fault action byte layout and the soft-connect DAC mode code
  localparam int ACT_HI = 7;
  localparam int ACT_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] DAC_MODE_SOFT = 2'h0;

  // Status bit positions
  localparam int VS_OV_FAULT = 7;
  localparam int VS_UV_FAULT = 4;
  localparam int VS_TON_MAX = 2;
  localparam int SB_VOUT_OV = 5;
  localparam int SB_OTHER = 0;
  localparam int SW_VOUT = 15;

  typedef enum {
    SSF_OFF, SSF_ON_WAIT, SSF_RISE, SSF_RUN, SSF_OFF_WAIT, SSF_RETRY_WAIT, SSF_LATCHED
  } ssf_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] index;
    logic [15:0] wdata;
  } ssf_cmd_t;

  typedef struct packed {
    logic [5:0] vin;
    logic [3:0] temp;
  } ssf_limit_flags_t;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic share_s1;
    logic share_s2;
    logic share_prev;
    logic [7:0] tick_div;
    logic [9:0] alive_cnt;
    logic [7:0] samp_div;
    logic [15:0][15:0] regs;
    logic [15:0] rdata;
    ssf_state_t state;
    logic [16:0] cnt;
    logic [16:0] max_cnt;
    logic uv_unmask;
    logic [2:0] ov_retry;
    logic [2:0] uv_retry;
    logic [2:0] ov_deg;
    logic [2:0] uv_deg;
    logic [7:0] vout_status;
    logic [7:0] sum_byte;
    logic [15:0] sum_word;
    ssf_limit_flags_t flags;
    logic supply_en;
    logic trim_connect;
  } ssf_state_reg_t;
endpackage
`default_nettype wire

// *** bench/ssf_sequencer_assertions.sv ***
`default_nettype none
module ssf_sequencer_assertions
  import ssf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire ssf_cmd_t cmd,
  input wire logic [15:0] cmd_rdata,
  input wire logic [1:0] dac_mode,
  input wire logic current_sense_mode,
  input wire logic out_over_detect,
  input wire logic supply_enable,
  input wire logic trim_connect,
  input wire logic [7:0] vout_status,
  input wire logic [7:0] summary_byte,
  input wire logic [15:0] summary_word,
  input wire logic alert_line_low_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence wr_s;
    cmd.valid && cmd.write && cmd.index < IDX_OUT_OVER_ACTION;
  endsequence
  sequence rd_s;
    cmd.valid && !cmd.write && cmd.index == $past(cmd.index, 2);
  endsequence
  chk_read_after_write: assert property (
    wr_s ##2 rd_s |=> cmd_rdata == $past(cmd.wdata, 3))
    else $error("read data differs from written word");
  chk_read_holds: assert property (
    !(cmd.valid && !cmd.write) |=> $stable(cmd_rdata))
    else $error("read data moved without a read");
  chk_alert_follows: assert property (
    alert_line_low_oe == (|vout_status))
    else $error("alert does not follow status");
  chk_ov_cause: assert property (
    $rose(vout_status[VS_OV_FAULT]) |-> $past(out_over_detect, 1) || $past(out_over_detect, 2)
      || $past(out_over_detect, 3) || $past(out_over_detect, 4))
    else $error("over status without detect");
  chk_ov_summary: assert property (
    vout_status[VS_OV_FAULT] |-> summary_byte[SB_VOUT_OV] && summary_word[SW_VOUT])
    else $error("summary bits missing");
  chk_sense_ignore: assert property (
    current_sense_mode [*5] |-> !$rose(vout_status[VS_OV_FAULT]) && !$rose(vout_status[VS_UV_FAULT]))
    else $error("fault taken in current mode");
  chk_trim_soft: assert property (
    $rose(trim_connect) |-> dac_mode == DAC_MODE_SOFT && supply_enable)
    else $error("trim connected wrongly");
  chk_timeout_off: assert property (
    $rose(vout_status[VS_TON_MAX]) |-> !supply_enable)
    else $error("supply on after start timeout");
endmodule // ssf_sequencer_assertions
`default_nettype wire

// *** bench/ssf_supply_model.sv ***
`default_nettype none
module ssf_supply_model (
  input wire logic sys_clk,
  input wire logic supply_enable,
  input wire logic share_run,
  input wire logic [7:0] up_cyc,
  output logic share_clk,
  output logic out_under_detect
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] up_q;
  logic [2:0] div_q;
  initial begin
    share_clk = 1'b0;
    up_q = 8'h00;
    div_q = 3'h0;
  end
  // Share clock stands still when stopped, never free running
  always @(posedge sys_clk) begin
    div_q <= div_q + 3'h1;
    if (share_run && div_q == 3'h3) share_clk <= ~share_clk;
    up_q <= !supply_enable ? 8'h00 : (up_q == 8'hFE ? up_q : up_q + 8'h01);
  end
  // All ones means the output never comes up
  assign out_under_detect = (up_cyc == 8'hFF) || (up_q < up_cyc);
endmodule // ssf_supply_model
`default_nettype wire

// *** bench/ssf_sequencer_tb.sv ***
`default_nettype none
module ssf_sequencer_tb import ssf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rstn, channel_on_pin, operation_on, share_clk, share_run, current_sense_mode;
  logic out_over_detect, out_under_detect, clear_faults, supply_enable, trim_connect;
  logic alert_line_low_oe;
  logic [1:0] dac_mode;
  logic [7:0] up_cyc, vout_status, summary_byte;
  logic [15:0] retry_wait_ticks, sensed_input_voltage, die_temperature, cmd_rdata, summary_word;
  logic [15:0] lim [16];
  logic [15:0] tset [6] = '{16'hD801, 16'hD801, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
  ssf_cmd_t cmd;
  ssf_limit_flags_t limit_flags;
  int err_count, checks, seed, i, k, n;
  ssf_sequencer #(.TICK_CYCLES(4), .SAMPLE_CYCLES(4), .ALIVE_CYCLES(40)) ssf_sequencer_i (
    .sys_clk, .rstn, .cmd, .cmd_rdata, .channel_on_pin, .operation_on, .share_clk, .dac_mode,
    .current_sense_mode, .out_over_detect, .out_under_detect, .clear_faults, .retry_wait_ticks,
    .sensed_input_voltage, .die_temperature, .supply_enable, .trim_connect, .vout_status,
    .summary_byte, .summary_word, .limit_flags, .alert_line_low_oe);
  ssf_supply_model ssf_supply_model_i (
    .sys_clk, .supply_enable, .share_run, .up_cyc, .share_clk, .out_under_detect);
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  task automatic acc(input logic w, input logic [3:0] x, input logic [15:0] d);
    @(negedge sys_clk);
    cmd = '{1'b1, w, x, d};
    @(negedge sys_clk);
    cmd.valid = 1'b0;
  endtask
  task automatic wsup(input logic v);
    for (n = 0; n < 400 && supply_enable !== v; n++) @(negedge sys_clk);
    chk("supply_enable", 16'(supply_enable), 16'(v));
  endtask
  task automatic ov_pulse(input int c);
    out_over_detect = 1'b1;
    tick(c);
    out_over_detect = 1'b0;
  endtask
  task automatic clear();
    clear_faults = 1'b1;
    tick(1);
    clear_faults = 1'b0;
    tick(1);
  endtask
  function automatic logic [15:0] eflags();
    ssf_limit_flags_t f;
    f.vin = {sensed_input_voltage < lim[5], sensed_input_voltage < lim[4],
      sensed_input_voltage > lim[3], sensed_input_voltage > lim[2],
      sensed_input_voltage < lim[1], sensed_input_voltage >= lim[0]};
    f.temp = {die_temperature < lim[9], die_temperature < lim[8],
      die_temperature > lim[7], die_temperature > lim[6]};
    return 16'(f);
  endfunction
  task automatic summarize();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    tick(20000);
    err_count++;
    summarize();
  end
  initial begin
    seed = 67181;
    {rstn, channel_on_pin, operation_on, share_run, current_sense_mode} = 5'h00;
    {out_over_detect, clear_faults, dac_mode} = 4'h0;
    up_cyc = 8'h14;
    retry_wait_ticks = 16'h0002;
    sensed_input_voltage = 16'h0000;
    die_temperature = 16'h0000;
    cmd = '0;
    tick(4);
    rstn = 1'b1;
    for (i = 0; i < 16; i++) begin
      lim[i] = 16'($random(seed));
      acc(1'b1, 4'(i), lim[i]);
      acc(1'b0, 4'(i), 16'h0000);
      tick(1);
      chk("register", cmd_rdata, i > 13 ? lim[i] & BYTE_MASK : lim[i]);
    end
    // Exponent zero keeps the limit words directly comparable
    for (k = 0; k < 5; k++) begin
      for (i = 0; i < 10; i++) begin
        lim[i] = 16'($random(seed)) & 16'h03FF;
        acc(1'b1, 4'(i), lim[i]);
      end
      sensed_input_voltage = (k == 4) ? lim[0] : 16'($random(seed)) & 16'h03FF;
      die_temperature = 16'($random(seed)) & 16'h03FF;
      tick(3);
      chk("limit_flags", 16'(limit_flags), eflags());
    end
    foreach (tset[j]) acc(1'b1, 4'(j + 10), tset[j]);
    channel_on_pin = 1'b1;
    tick(100);
    chk("on without share", 16'(supply_enable), 16'h0000);
    share_run = 1'b1;
    tick(20);
    chk("on wait early", 16'(supply_enable), 16'h0000);
    wsup(1'b1);
    for (n = 0; n < 400 && trim_connect !== 1'b1; n++) @(negedge sys_clk);
    chk("trim_connect", 16'(trim_connect), 16'h0001);
    ov_pulse(10);
    tick(3);
    chk("status", {vout_status, summary_byte}, 16'h8020);
    chk("summary_word", summary_word, 16'h8020);
    chk("alert", 16'(alert_line_low_oe), 16'h0001);
    chk("kept on", 16'(supply_enable), 16'h0001);
    clear();
    chk("cleared", 16'(vout_status), 16'h0000);
    acc(1'b1, IDX_OUT_OVER_ACTION, 16'h0043);
    ov_pulse(5);
    tick(30);
    chk("glitch", 16'(supply_enable), 16'h0001);
    clear();
    ov_pulse(40);
    chk("deglitched off", 16'(supply_enable), 16'h0000);
    tick(100);
    chk("latched", 16'(supply_enable), 16'h0000);
    clear();
    wsup(1'b1);
    acc(1'b1, IDX_OUT_OVER_ACTION, 16'h0088);
    channel_on_pin = 1'b0;
    wsup(1'b0);
    operation_on = 1'b1;
    wsup(1'b1);
    ov_pulse(6);
    chk("shut at once", 16'(supply_enable), 16'h0000);
    wsup(1'b1);
    clear();
    current_sense_mode = 1'b1;
    tick(6);
    ov_pulse(20);
    tick(4);
    chk("sense", {vout_status, 7'h00, supply_enable}, 16'h0001);
    current_sense_mode = 1'b0;
    acc(1'b1, IDX_TURN_OFF_WAIT, 16'hD801);
    share_run = 1'b0;
    operation_on = 1'b0;
    tick(8);
    chk("off wait", 16'(supply_enable), 16'h0001);
    wsup(1'b0);
    acc(1'b1, IDX_START_TIMEOUT, 16'hD801);
    up_cyc = 8'hFF;
    share_run = 1'b1;
    operation_on = 1'b1;
    wsup(1'b1);
    wsup(1'b0);
    chk("start timeout", 16'(vout_status), 16'h0004);
    operation_on = 1'b0;
    tick(4);
    clear();
    acc(1'b1, IDX_START_TIMEOUT, 16'h0000);
    dac_mode = 2'h1;
    operation_on = 1'b1;
    wsup(1'b1);
    tick(300);
    chk("no limit", {vout_status, 7'h00, supply_enable}, 16'h0001);
    chk("trim other mode", 16'(trim_connect), 16'h0000);
    summarize();
  end
endmodule // ssf_sequencer_tb
bind ssf_sequencer ssf_sequencer_assertions ssf_sequencer_assertions_i (
  .sys_clk, .rstn, .cmd, .cmd_rdata, .dac_mode, .current_sense_mode, .out_over_detect,
  .supply_enable, .trim_connect, .vout_status, .summary_byte, .summary_word, .alert_line_low_oe);
`default_nettype wire
